/* nvcfg_consts.svh */
`ifndef NVCFG_CONSTS_SVH
`define NVCFG_CONSTS_SVH

// Instruction codes of the two register instructions.
`define NVC_OPC_RD      8'hb5
`define NVC_OPC_WR      8'hb1

// Register width, factory value and serial framing.
`define NVC_WIDTH       16
`define NVC_FACTORY     16'hffff
`define NVC_OPC_BITS    6'd8
`define NVC_FRAME_BITS  6'd24
`define NVC_DATA_BITS   5'd16

// Field positions.
`define NVC_DUMMY_HI    15
`define NVC_DUMMY_LO    12
`define NVC_XIP_HI      11
`define NVC_XIP_LO      9
`define NVC_DRV_HI      8
`define NVC_DRV_LO      6
`define NVC_HOLD_BIT    4
`define NVC_QUAD_BIT    3
`define NVC_DUAL_BIT    2

// Reserved bits 5 and 1..0 always read as one.
`define NVC_RSV_MASK    16'h0023

// Field codes.
`define NVC_DUMMY_ZERO  4'h0
`define NVC_DUMMY_MAX   4'hf
`define NVC_XIP_LAST    3'h4

`endif

/* nvcfg_pkg.sv */
package nvcfg_pkg;

	typedef enum logic [1:0] {
		NVCFG_SINGLE,
		NVCFG_DUAL,
		NVCFG_QUAD
	} nvcfg_proto_t;

	typedef enum logic {
		NVCFG_BOOT,
		NVCFG_RUN
	} nvcfg_state_t;

	// Working side, on ref_clk.
	typedef struct packed {
		nvcfg_state_t state;
		logic [15:0]  work;
		logic         tgl_seen;
	} nvcfg_ref_t;

	// Per-frame link state, cleared while chip select is high.
	typedef struct packed {
		logic [5:0]  cnt;
		logic [23:0] sh;
		logic        is_rd;
		logic [15:0] out;
		logic [4:0]  ocnt;
		logic [3:0]  dq_o;
		logic [3:0]  oe;
	} nvcfg_frm_t;

	// Link state that outlives a frame.
	typedef struct packed {
		logic        wr_tgl;
		logic [15:0] wr_data;
	} nvcfg_hold_t;

endpackage

/* nvcfg_sync.sv */
`timescale 1ns/1ps

module nvcfg_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

/* nvcfg_top.sv */
// Behaviour
// - Factory-erased register holds all ones.
// - Contents apply only at next power-on.
// - Read and write instructions in all protocols.
// - Bits 15..12 give fast-read dummy count.
// - Codes 1..15 direct; zero acts as fifteen.
// - All-ones code selects full-speed dummy count.
// - Bit 4 low disables hold/reset function.
// - Bit 3 low enables quad command input.
// - Bit 2 low enables dual command input.
// - Reserved bits ignored and read as one.
// - Both enables low starts in quad.
// - Bits 11..9 choose power-on execute-in-place mode.
`timescale 1ns/1ps
`include "nvcfg_consts.svh"

module nvcfg_top (
	// Clock, power-on reset, clock enable
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       ce,
	// Factory erase of the non-volatile cell
	input  wire logic       factory_clr_b,
	// Serial link
	input  wire logic       sclk,
	input  wire logic       cs_b,
	input  wire logic [3:0] dq_in,
	output logic      [3:0] dq_out,
	output logic      [3:0] dq_oe,
	// Working configuration
	output logic [3:0]      dummy_cycles,
	output logic [2:0]      xip_mode,
	output logic            xip_active,
	output logic [2:0]      drive_strength,
	output logic            hold_reset_en,
	output logic [1:0]      protocol,
	output logic            cfg_ready
);

	logic                  rst_q;
	logic                  fclr_q;
	logic [15:0]           nv_cell_r;
	logic [15:0]           rd_view;
	logic                  wr_tgl_s;
	logic                  wr_edge;
	logic [17:0]           to_link;
	logic [17:0]           to_link_s;
	nvcfg_pkg::nvcfg_ref_t  st_r, st_nxt;
	nvcfg_pkg::nvcfg_frm_t  frm_r, frm_nxt;
	nvcfg_pkg::nvcfg_hold_t hold_r, hold_nxt;

	nvcfg_sync #(.W(1)) u_rst_sync (
		.clk   (ref_clk),
		.rst_b (rst_b),
		.d     (1'b1),
		.q     (rst_q)
	);

	nvcfg_sync #(.W(1)) u_fclr_sync (
		.clk   (ref_clk),
		.rst_b (factory_clr_b),
		.d     (1'b1),
		.q     (fclr_q)
	);

	nvcfg_sync #(.W(1)) u_tgl_sync (
		.clk   (ref_clk),
		.rst_b (rst_q),
		.d     (hold_r.wr_tgl),
		.q     (wr_tgl_s)
	);

	// The word is quasi-static, so it is taken as each frame opens and held for that frame.
	always_ff @(negedge cs_b) begin
		to_link_s <= to_link;
	end

	assign rd_view = nv_cell_r | `NVC_RSV_MASK;
	assign to_link = {protocol, rd_view};
	assign wr_edge = wr_tgl_s ^ st_r.tgl_seen;

	// The cell survives power-on reset; only a factory erase returns it to all ones.
	always_ff @(posedge ref_clk or negedge fclr_q) begin
		if (!fclr_q) begin
			nv_cell_r <= `NVC_FACTORY;
		end else if (ce && wr_edge) begin
			nv_cell_r <= hold_r.wr_data;
		end
	end

	always_comb begin
		st_nxt = st_r;
		if (wr_edge) begin
			st_nxt.tgl_seen = wr_tgl_s;
		end
		case (st_r.state)
			nvcfg_pkg::NVCFG_BOOT: begin
				st_nxt.work  = nv_cell_r;
				st_nxt.state = nvcfg_pkg::NVCFG_RUN;
			end
			nvcfg_pkg::NVCFG_RUN: begin
				st_nxt.work = st_r.work;
			end
			default: begin
				st_nxt.state = nvcfg_pkg::NVCFG_BOOT;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_q) begin
		if (!rst_q) begin
			st_r <= '{state: nvcfg_pkg::NVCFG_BOOT, work: `NVC_FACTORY, tgl_seen: 1'b0};
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	always_comb begin
		if (st_r.work[`NVC_DUMMY_HI:`NVC_DUMMY_LO] == `NVC_DUMMY_ZERO) begin
			dummy_cycles = `NVC_DUMMY_MAX;
		end else begin
			dummy_cycles = st_r.work[`NVC_DUMMY_HI:`NVC_DUMMY_LO];
		end
		if (!st_r.work[`NVC_QUAD_BIT]) begin
			protocol = nvcfg_pkg::NVCFG_QUAD;
		end else if (!st_r.work[`NVC_DUAL_BIT]) begin
			protocol = nvcfg_pkg::NVCFG_DUAL;
		end else begin
			protocol = nvcfg_pkg::NVCFG_SINGLE;
		end
	end

	assign xip_mode       = st_r.work[`NVC_XIP_HI:`NVC_XIP_LO];
	assign xip_active     = (xip_mode <= `NVC_XIP_LAST);
	assign drive_strength = st_r.work[`NVC_DRV_HI:`NVC_DRV_LO];
	assign hold_reset_en  = st_r.work[`NVC_HOLD_BIT];
	assign cfg_ready      = (st_r.state == nvcfg_pkg::NVCFG_RUN);

	// Link side: instruction and data enter on 1, 2 or 4 lines, msb first.
	always_comb begin
		logic [2:0]  step;
		logic [3:0]  bits;
		logic [5:0]  cnt_n;
		logic [4:0]  ocnt_n;
		logic [23:0] sh_n;
		step     = 3'd1;
		bits     = 4'h0;
		cnt_n    = 6'd0;
		ocnt_n   = 5'd0;
		sh_n     = 24'h000000;
		frm_nxt  = frm_r;
		hold_nxt = hold_r;
		case (nvcfg_pkg::nvcfg_proto_t'(to_link_s[17:16]))
			nvcfg_pkg::NVCFG_QUAD: begin
				step = 3'd4;
				bits = dq_in;
			end
			nvcfg_pkg::NVCFG_DUAL: begin
				step = 3'd2;
				bits = {2'b00, dq_in[1:0]};
			end
			default: begin
				step = 3'd1;
				bits = {3'b000, dq_in[0]};
			end
		endcase
		cnt_n = 6'(frm_r.cnt + {3'b000, step});
		sh_n  = (frm_r.sh << step) | {20'h00000, bits};
		if (frm_r.cnt < `NVC_FRAME_BITS) begin
			frm_nxt.cnt = cnt_n;
			frm_nxt.sh  = sh_n;
			if (frm_r.cnt < `NVC_OPC_BITS && cnt_n == `NVC_OPC_BITS
					&& sh_n[7:0] == `NVC_OPC_RD) begin
				frm_nxt.is_rd = 1'b1;
				frm_nxt.out   = to_link_s[15:0];
				frm_nxt.ocnt  = 5'd0;
			end
			if (!frm_r.is_rd && cnt_n == `NVC_FRAME_BITS && sh_n[23:16] == `NVC_OPC_WR) begin
				hold_nxt.wr_data = sh_n[15:0];
				hold_nxt.wr_tgl  = ~hold_r.wr_tgl;
			end
		end
		if (frm_r.is_rd) begin
			case (step)
				3'd4: begin
					frm_nxt.dq_o = frm_r.out[15:12];
					frm_nxt.oe   = 4'b1111;
				end
				3'd2: begin
					frm_nxt.dq_o = {2'b00, frm_r.out[15:14]};
					frm_nxt.oe   = 4'b0011;
				end
				default: begin
					frm_nxt.dq_o = {2'b00, frm_r.out[15], 1'b0};
					frm_nxt.oe   = 4'b0010;
				end
			endcase
			ocnt_n = 5'(frm_r.ocnt + {2'b00, step});
			if (ocnt_n >= `NVC_DATA_BITS) begin
				frm_nxt.out  = to_link_s[15:0];
				frm_nxt.ocnt = 5'd0;
			end else begin
				frm_nxt.out  = frm_r.out << step;
				frm_nxt.ocnt = ocnt_n;
			end
		end
	end

	always_ff @(posedge sclk or posedge cs_b) begin
		if (cs_b) begin
			frm_r <= '0;
		end else begin
			frm_r <= frm_nxt;
		end
	end

	always_ff @(posedge sclk or negedge rst_q) begin
		if (!rst_q) begin
			hold_r <= '0;
		end else begin
			hold_r <= hold_nxt;
		end
	end

	assign dq_out = frm_r.dq_o;
	assign dq_oe  = frm_r.oe;

	property p_erase;
		@(posedge ref_clk) $rose(fclr_q) |-> nv_cell_r == `NVC_FACTORY;
	endproperty
	a_erase: assert property (p_erase) else $error("cell not all ones after erase");

	property p_run_stable;
		@(posedge ref_clk) disable iff (!rst_q)
		st_r.state == nvcfg_pkg::NVCFG_RUN && $past(st_r.state) == nvcfg_pkg::NVCFG_RUN
		|-> $stable(st_r.work);
	endproperty
	a_run_stable: assert property (p_run_stable) else $error("working config changed live");

	property p_boot;
		@(posedge ref_clk) disable iff (!rst_q)
		st_r.state == nvcfg_pkg::NVCFG_BOOT && ce |=> st_r.work == $past(nv_cell_r) && cfg_ready;
	endproperty
	a_boot: assert property (p_boot) else $error("boot did not load cell");

	property p_commit;
		@(posedge ref_clk) disable iff (!rst_q || !fclr_q)
		wr_edge && ce |=> nv_cell_r == $past(hold_r.wr_data) ##1 !wr_edge [*2];
	endproperty
	a_commit: assert property (p_commit) else $error("write not committed");

	property p_rd_drive;
		@(posedge sclk) disable iff (cs_b)
		$rose(frm_r.is_rd) |=> dq_oe != 4'h0 ##1 dq_oe != 4'h0;
	endproperty
	a_rd_drive: assert property (p_rd_drive) else $error("read data not driven");

	property p_dummy;
		@(posedge ref_clk) disable iff (!rst_q)
		st_r.work[15:12] != 4'h0 |-> dummy_cycles == st_r.work[15:12];
	endproperty
	a_dummy: assert property (p_dummy) else $error("dummy count wrong");

	property p_dummy_zero;
		@(posedge ref_clk) disable iff (!rst_q)
		st_r.work[15:12] == 4'h0 |-> dummy_cycles == 4'hf;
	endproperty
	a_dummy_zero: assert property (p_dummy_zero) else $error("zero code not fifteen");

	property p_hold;
		@(posedge ref_clk) disable iff (!rst_q)
		$changed(st_r.work[4]) |-> hold_reset_en == st_r.work[4];
	endproperty
	a_hold: assert property (p_hold) else $error("hold enable wrong");

	property p_quad;
		@(posedge ref_clk) disable iff (!rst_q)
		!st_r.work[3] |-> protocol == nvcfg_pkg::NVCFG_QUAD;
	endproperty
	a_quad: assert property (p_quad) else $error("quad not selected");

	property p_dual;
		@(posedge ref_clk) disable iff (!rst_q)
		st_r.work[3] && !st_r.work[2] |-> protocol == nvcfg_pkg::NVCFG_DUAL;
	endproperty
	a_dual: assert property (p_dual) else $error("dual not selected");

	property p_rsv;
		@(posedge ref_clk) rd_view[5] && rd_view[1:0] == 2'b11;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits not one");

	property p_xip;
		@(posedge ref_clk) disable iff (!rst_q)
		st_r.work[11:9] == 3'h7 |-> !xip_active;
	endproperty
	a_xip: assert property (p_xip) else $error("xip not disabled");
endmodule

/* nvcfg_host.sv */
`timescale 1ns/1ps

module nvcfg_host (
	// Serial link towards the device
	output logic            sclk,
	output logic            cs_b,
	output logic      [3:0] dq_in,
	input  wire logic [3:0] dq_out,
	input  wire logic [3:0] dq_oe
);
	initial begin
		sclk = 1'b0;
		cs_b = 1'b1;
		dq_in = 4'h5;
	end

	// Register instructions and one unknown opcode (9f) are sent, never a fast read.
	// One instruction per frame, lanes per protocol, msb first.
	task automatic xfer(input logic [1:0] pr, input logic [7:0] op, input logic [15:0] wd,
			input bit rd, output logic [15:0] q, output logic [3:0] oe);
		int          w;
		int          n;
		logic [23:0] sh;
		w = (pr == 2'd2) ? 4 : ((pr == 2'd1) ? 2 : 1);
		sh = {op, wd};
		n = rd ? (8 / w + 16 / w + 1) : 24 / w;
		q = 16'h0000;
		oe = 4'h0;
		cs_b = 1'b0;
		for (int e = 0; e < n; e++) begin
			if (rd && e >= 8 / w) begin
				dq_in = ~dq_in;
			end else begin
				dq_in = sh[23 -: 4] >> (4 - w);
				sh = sh << w;
			end
			#6;
			if (rd && e > 8 / w) begin
				q = (w == 4) ? {q[11:0], dq_out} :
					((w == 2) ? {q[13:0], dq_out[1:0]} : {q[14:0], dq_out[1]});
				oe = dq_oe;
			end
			sclk = 1'b1;
			#6;
			sclk = 1'b0;
		end
		#6;
		cs_b = 1'b1;
		dq_in = ~dq_in;
		#12;
	endtask
endmodule

/* tb_nvcfg_top.sv */
`timescale 1ns/1ps
`include "nvcfg_consts.svh"

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
	$display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end

module tb_nvcfg_top;
	logic        ref_clk;
	logic        rst_b;
	logic        ce;
	logic        factory_clr_b;
	logic        sclk;
	logic        cs_b;
	logic [3:0]  dq_in;
	logic [3:0]  dq_out;
	logic [3:0]  dq_oe;
	logic [3:0]  dummy_cycles;
	logic [2:0]  xip_mode;
	logic        xip_active;
	logic [2:0]  drive_strength;
	logic        hold_reset_en;
	logic [1:0]  protocol;
	logic        cfg_ready;
	int          errors;
	int          cmp_count;
	int          cyc;
	logic [31:0] rnd;
	logic [15:0] cur;
	logic [15:0] v;
	logic [15:0] q;
	logic [3:0]  oe;
	logic [15:0] corner [4] = '{16'h0000, 16'hfffb, 16'hfff7, 16'h1bff};

	nvcfg_top uut (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .factory_clr_b(factory_clr_b),
		.sclk(sclk), .cs_b(cs_b), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.dummy_cycles(dummy_cycles), .xip_mode(xip_mode), .xip_active(xip_active),
		.drive_strength(drive_strength), .hold_reset_en(hold_reset_en),
		.protocol(protocol), .cfg_ready(cfg_ready));

	nvcfg_host host (.sclk(sclk), .cs_b(cs_b), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

	function automatic logic [31:0] xorshift(logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic logic [1:0] exp_proto(logic [15:0] c);
		return !c[3] ? 2'd2 : (!c[2] ? 2'd1 : 2'd0);
	endfunction

	function automatic logic [3:0] exp_oe(logic [15:0] c);
		return (exp_proto(c) == 2'd2) ? 4'hf : ((exp_proto(c) == 2'd1) ? 4'h3 : 4'h2);
	endfunction

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic do_reset;
		@(negedge ref_clk);
		rst_b = 1'b0;
		repeat (4) @(negedge ref_clk);
		rst_b = 1'b1;
		repeat (8) @(negedge ref_clk);
	endtask

	task automatic check_cfg(input logic [15:0] c);
		`CHK(dummy_cycles, (c[15:12] == 4'h0) ? 4'hf : c[15:12])
		`CHK(xip_mode, c[11:9])
		`CHK(xip_active, (c[11:9] <= 3'h4))
		`CHK(drive_strength, c[8:6])
		`CHK(hold_reset_en, c[4])
		`CHK(protocol, exp_proto(c))
		`CHK(cfg_ready, 1'b1)
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			errors++;
			report_and_stop();
		end
	end

	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		factory_clr_b = 1'b0;
		rnd = 32'h34ba;
		do_reset();
		factory_clr_b = 1'b1;
		cur = `NVC_FACTORY;
		check_cfg(cur);
		// An unknown opcode with data behind it must leave the cell alone.
		host.xfer(2'd0, 8'h9f, 16'h0000, 1'b0, q, oe);
		repeat (12) @(negedge ref_clk);
		host.xfer(2'd0, `NVC_OPC_RD, 16'h0000, 1'b1, q, oe);
		`CHK(q, 16'hffff)
		// Boot must wait while the clock enable is low.
		ce = 1'b0;
		do_reset();
		`CHK(cfg_ready, 1'b0)
		`CHK(dummy_cycles, 4'hf)
		ce = 1'b1;
		repeat (4) @(negedge ref_clk);
		check_cfg(cur);
		for (int i = 0; i < 12; i++) begin
			rnd = xorshift(rnd);
			v = (i < 4) ? corner[i] : rnd[15:0];
			host.xfer(exp_proto(cur), `NVC_OPC_WR, v, 1'b0, q, oe);
			repeat (12) @(negedge ref_clk);
			check_cfg(cur);
			host.xfer(exp_proto(cur), `NVC_OPC_RD, 16'h0000, 1'b1, q, oe);
			`CHK(q, v | `NVC_RSV_MASK)
			`CHK(oe, exp_oe(cur))
			do_reset();
			check_cfg(v);
			cur = v;
			host.xfer(exp_proto(cur), `NVC_OPC_RD, 16'h0000, 1'b1, q, oe);
			`CHK(q, v | `NVC_RSV_MASK)
			$display("test %0d value %h done", i, v);
		end
		report_and_stop();
	end
endmodule
